//--- rpq_pkg.sv
// Shared constants and types for the receive-port pass qualifier
package rpq_pkg;

    // ------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RPQ_CTRL_OFFSET = 8'h7D;
    localparam logic [7:0] RPQ_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Widths and timing figures
    // ------------------------------------------------------------
    localparam int RPQ_LEN_W = 16;
    localparam int RPQ_WDOG_W = 24;
    // Frame periods allowed between valid frame ends
    localparam int RPQ_WDOG_PERIODS = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic discard_en;
        logic zero_counts_when_unqualified;
        logic check_lines_per_frame;
        logic check_line_size;
        logic parity_mode;
        logic frame_end_watchdog_disable;
        logic [1:0] threshold;
    } rpq_ctrl_t;

    // Per-cycle events from the receive video path
    typedef struct packed {
        logic line_end;
        logic [RPQ_LEN_W-1:0] line_len;
        logic frame_end;
        logic parity_err;
    } rpq_video_t;

    // Line readback bytes as software sees them
    typedef struct packed {
        logic [7:0] line_count_readback_hi;
        logic [7:0] line_count_readback_lo;
        logic [7:0] line_length_readback_hi;
        logic [7:0] line_length_readback_lo;
    } rpq_readback_t;

    typedef enum logic [1:0] {
        RPQ_UNLOCKED = 2'b00,
        RPQ_COUNTING = 2'b01,
        RPQ_QUALIFIED = 2'b11
    } rpq_state_t;

endpackage

//--- rpq_frame_stats.sv
// Line-per-frame and line-size tracking with change detection
module rpq_frame_stats #(
    parameter int LEN_W = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic rx_lock,
    input wire logic line_end,
    input wire logic [LEN_W-1:0] line_len,
    input wire logic frame_end,
    output logic size_change,
    output logic count_change,
    output logic [LEN_W-1:0] lines_per_frame,
    output logic [LEN_W-1:0] line_length
);
    logic [LEN_W-1:0] line_cnt;
    logic have_len;
    logic have_lines;
    wire [LEN_W-1:0] lines_this_frame = line_cnt + LEN_W'(line_end);

    // ------------------------------------------------------------
    // Change detection; first sample after lock only seeds history
    // ------------------------------------------------------------
    assign size_change = line_end && have_len && (line_len != line_length);
    assign count_change = frame_end && have_lines &&
        (lines_this_frame != lines_per_frame);

    // History restarts on lock loss so a new camera is not flagged
    always_ff @(posedge clk_sys) begin
        if (srst || !rx_lock) begin
            line_cnt <= '0;
            have_len <= 1'b0;
            have_lines <= 1'b0;
            line_length <= '0;
            lines_per_frame <= '0;
        end else begin
            if (line_end) begin
                line_length <= line_len;
                have_len <= 1'b1;
            end
            if (frame_end) begin
                lines_per_frame <= lines_this_frame;
                have_lines <= 1'b1;
                line_cnt <= '0;
            end else if (line_end) begin
                line_cnt <= line_cnt + LEN_W'(1);
            end
        end
    end

    size_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        line_end && have_len && line_len != line_length |-> size_change)
        else $error("line size change not flagged");

endmodule // rpq_frame_stats

//--- rpq_frame_watchdog.sv
// Frame-end watchdog: times out after two measured frame periods
module rpq_frame_watchdog #(
    parameter int CNT_W = 24
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic rx_lock,
    input wire logic frame_end,
    input wire logic enable,
    output logic timeout
);
    import rpq_pkg::*;

    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] period;
    logic armed;
    wire [CNT_W+1:0] limit = (CNT_W+2)'(period) *
        (CNT_W+2)'(RPQ_WDOG_PERIODS);
    wire expired = armed && enable && ((CNT_W+2)'(elapsed) > limit);

    // ------------------------------------------------------------
    // Period measure; disarms after firing to give one pulse only
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || !rx_lock) begin
            elapsed <= '0;
            period <= '0;
            armed <= 1'b0;
            timeout <= 1'b0;
        end else begin
            timeout <= expired;
            if (frame_end) begin
                period <= elapsed;
                armed <= 1'b1;
                elapsed <= '0;
            end else if (expired) begin
                armed <= 1'b0;
            end else if (!(&elapsed)) begin
                elapsed <= elapsed + CNT_W'(1);
            end
        end
    end

    wdog_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
        expired && rx_lock |=> timeout ##1 !timeout)
        else $error("watchdog timeout not a single pulse");

endmodule // rpq_frame_watchdog

//--- rpq_port_qualifier.sv
// Receive-port pass qualifier: control register, state, gating
// Function
// [RQ1] Discard packets while unqualified when enabled
// [RQ2] Readbacks read zero while unqualified if set
// [RQ3] Lines-per-frame change drops qualification
// [RQ4] Line size change drops qualification
// [RQ5] Parity mode 0: dip per parity error
// [RQ6] Parity mode 1: clear until threshold met
// [RQ7] Watchdog drops on missing frame end
// [RQ8] Watchdog ignored when threshold is zero
// [RQ9] Threshold zero: qualify on receiver lock
// [RQ10] Nonzero threshold: qualify after that many frames
// [RQ11] Software selects port before register access
// [RQ12] Resume forwarding after truncation once threshold met
// [RQ13] Reset or lock loss clears state and count
module rpq_port_qualifier #(
    parameter int LEN_W = rpq_pkg::RPQ_LEN_W,
    parameter int WDOG_W = rpq_pkg::RPQ_WDOG_W
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic reg_port_sel,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic rx_lock,
    input wire rpq_pkg::rpq_video_t video,
    input wire logic pkt_valid,
    output logic pkt_fwd,
    output logic qualified,
    output rpq_pkg::rpq_readback_t readback
);
    import rpq_pkg::*;

    rpq_ctrl_t ctrl;
    rpq_state_t state;
    rpq_state_t next_state;
    logic [1:0] frame_cnt;
    logic [1:0] next_frame_cnt;
    logic size_change;
    logic count_change;
    logic wdog_timeout;
    logic [LEN_W-1:0] lines_per_frame;
    logic [LEN_W-1:0] line_length;

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    // Only the selected port's copy answers
    wire ctrl_hit = reg_port_sel && (reg_addr == RPQ_CTRL_OFFSET); // [RQ11]
    wire [7:0] next_rdata = ctrl_hit ? ctrl : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl <= rpq_ctrl_t'(RPQ_CTRL_RESET);
        end else if (reg_wr && ctrl_hit) begin
            ctrl <= rpq_ctrl_t'(reg_wdata);
        end
    end

    // Read data registered; valid one cycle after address
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Frame statistics and watchdog
    // ------------------------------------------------------------
    rpq_frame_stats #(
        .LEN_W(LEN_W)
    ) u_stats (
        .clk_sys(clk_sys),
        .srst(srst),
        .rx_lock(rx_lock),
        .line_end(video.line_end),
        .line_len(video.line_len),
        .frame_end(video.frame_end),
        .size_change(size_change),
        .count_change(count_change),
        .lines_per_frame(lines_per_frame),
        .line_length(line_length)
    );

    // Watchdog only runs with a nonzero threshold
    wire thr_zero = (ctrl.threshold == 2'b00);
    wire wdog_enable = !ctrl.frame_end_watchdog_disable && !thr_zero; // [RQ8]

    rpq_frame_watchdog #(
        .CNT_W(WDOG_W)
    ) u_wdog (
        .clk_sys(clk_sys),
        .srst(srst),
        .rx_lock(rx_lock),
        .frame_end(video.frame_end),
        .enable(wdog_enable),
        .timeout(wdog_timeout)
    );

    // ------------------------------------------------------------
    // Qualification decisions
    // ------------------------------------------------------------
    wire drop_lines = ctrl.check_lines_per_frame && count_change; // [RQ3]
    wire drop_size = ctrl.check_line_size && size_change; // [RQ4]
    wire drop_parity = ctrl.parity_mode && video.parity_err; // [RQ6]
    wire drop_wdog = wdog_timeout && wdog_enable; // [RQ7]
    wire drop_any = drop_lines || drop_size || drop_parity || drop_wdog;
    // Mode 0 parity error only dips the output for one cycle
    wire parity_dip = video.parity_err && !ctrl.parity_mode; // [RQ5]
    wire [2:0] frames_seen = {1'b0, frame_cnt} + 3'h1;
    wire frames_met = frames_seen >= {1'b0, ctrl.threshold}; // [RQ10]

    // Any drop restarts counting; threshold 0 requalifies next cycle
    always_comb begin
        next_state = state;
        next_frame_cnt = frame_cnt;
        if (!rx_lock) begin
            next_state = RPQ_UNLOCKED; // [RQ13]
            next_frame_cnt = 2'h0;
        end else if (drop_any) begin
            next_state = RPQ_COUNTING;
            next_frame_cnt = 2'h0;
        end else begin
            unique case (state)
                RPQ_UNLOCKED: begin
                    next_state = thr_zero ? RPQ_QUALIFIED : RPQ_COUNTING; // [RQ9]
                end
                RPQ_COUNTING: begin
                    if (thr_zero) begin
                        next_state = RPQ_QUALIFIED;
                    end else if (video.frame_end && frames_met) begin
                        next_state = RPQ_QUALIFIED; // [RQ10] [RQ12]
                        next_frame_cnt = 2'h0;
                    end else if (video.frame_end) begin
                        next_frame_cnt = frame_cnt + 2'h1;
                    end
                end
                RPQ_QUALIFIED: begin
                    next_state = RPQ_QUALIFIED;
                end
                default: begin
                    next_state = RPQ_UNLOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= RPQ_UNLOCKED; // [RQ13]
            frame_cnt <= 2'h0;
        end else begin
            state <= next_state;
            frame_cnt <= next_frame_cnt;
        end
    end

    // Output flag follows state but drops for mode-0 parity errors
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            qualified <= 1'b0;
        end else begin
            qualified <= (next_state == RPQ_QUALIFIED) && !parity_dip; // [RQ5]
        end
    end

    // ------------------------------------------------------------
    // Packet gating and readback
    // ------------------------------------------------------------
    // Combinational so a packet is judged on the current flag
    assign pkt_fwd = pkt_valid && (!ctrl.discard_en || qualified); // [RQ1]

    wire zero_rb = ctrl.zero_counts_when_unqualified && !qualified; // [RQ2]

    always_ff @(posedge clk_sys) begin
        if (srst || zero_rb) begin
            readback <= '0;
        end else begin
            readback <= {lines_per_frame[15:8], lines_per_frame[7:0],
                line_length[15:8], line_length[7:0]};
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    discard_gate_a: assert property ( // [RQ1]
        ctrl.discard_en && !qualified |-> !pkt_fwd)
        else $error("packet forwarded while unqualified");

    forward_all_a: assert property ( // [RQ1]
        !ctrl.discard_en && pkt_valid |-> pkt_fwd)
        else $error("packet dropped with discard disabled");

    zero_read_a: assert property ( // [RQ2]
        ctrl.zero_counts_when_unqualified && !qualified |=> readback == '0)
        else $error("readback not zero while unqualified");

    live_read_a: assert property ( // [RQ2]
        !ctrl.zero_counts_when_unqualified
        |=> readback[31:16] == $past(lines_per_frame))
        else $error("line count readback not live");

    line_cnt_drop_a: assert property ( // [RQ3]
        rx_lock && ctrl.check_lines_per_frame && count_change
        |=> !qualified && state == RPQ_COUNTING)
        else $error("line count change did not drop qualification");

    line_size_drop_a: assert property ( // [RQ4]
        rx_lock && ctrl.check_line_size && size_change |=> !qualified)
        else $error("line size change did not drop qualification");

    parity_dip_a: assert property ( // [RQ5]
        video.parity_err && !ctrl.parity_mode |=> !qualified)
        else $error("parity error did not dip qualification");

    parity_hold_a: assert property ( // [RQ6]
        rx_lock && video.parity_err && ctrl.parity_mode && !thr_zero
        |=> !qualified ##1 !qualified)
        else $error("parity error did not hold qualification low");

    wdog_drop_a: assert property ( // [RQ7]
        rx_lock && wdog_timeout && wdog_enable |=> !qualified)
        else $error("watchdog timeout did not drop qualification");

    wdog_ignore_a: assert property ( // [RQ8]
        rx_lock && thr_zero && state == RPQ_QUALIFIED && !drop_any
        && !video.parity_err |=> qualified)
        else $error("qualification lost with threshold zero");

    lock_qual_a: assert property ( // [RQ9]
        rx_lock && thr_zero && state == RPQ_UNLOCKED && !drop_any
        && !video.parity_err |=> qualified)
        else $error("no qualification on lock with threshold zero");

    frame_qual_a: assert property ( // [RQ10]
        $rose(qualified) && $past(state) == RPQ_COUNTING
        && $past(ctrl.threshold) != 2'b00 |-> $past(video.frame_end))
        else $error("qualified without a valid frame end");

    resume_a: assert property ( // [RQ12]
        rx_lock && drop_lines && !thr_zero |=> state == RPQ_COUNTING)
        else $error("truncation did not restart frame counting");

    lock_loss_a: assert property ( // [RQ13]
        !rx_lock |=> !qualified && frame_cnt == 2'h0)
        else $error("lock loss did not clear qualification");

    // Register bus: only the selected port's copy changes or answers
    ctrl_write_a: assert property ( // [RQ11]
        reg_wr && ctrl_hit |=> ctrl == $past(reg_wdata))
        else $error("control write not taken");

    foreign_write_a: assert property ( // [RQ11]
        reg_wr && !reg_port_sel |=> $stable(ctrl))
        else $error("write to another port changed control");

    read_hit_a: assert property ( // [RQ11]
        ctrl_hit |=> reg_rdata == $past(ctrl))
        else $error("control readback wrong");

    read_miss_a: assert property ( // [RQ11]
        !ctrl_hit |=> reg_rdata == 8'h00)
        else $error("unselected read not zero");

    // Gating and readback while qualified
    fwd_qual_a: assert property ( // [RQ1]
        ctrl.discard_en && qualified && pkt_valid |-> pkt_fwd)
        else $error("packet dropped while qualified");

    live_len_a: assert property ( // [RQ2]
        ctrl.zero_counts_when_unqualified && qualified
        |=> readback[15:0] == $past(line_length))
        else $error("line length readback not live");

    // No frame end, no qualification while counting at a nonzero threshold
    no_early_a: assert property ( // [RQ10]
        rx_lock && state == RPQ_COUNTING && !thr_zero
        && !video.frame_end |=> !qualified)
        else $error("qualified before threshold frames");

    // Disabled watchdog must never reach the state machine
    wdog_off_a: assert property ( // [RQ7]
        ctrl.frame_end_watchdog_disable |-> !drop_wdog)
        else $error("disabled watchdog dropped qualification");

    // Reset itself is checked, so the default disable is lifted
    reset_clear_a: assert property (disable iff (1'b0) // [RQ13]
        srst |=> !qualified && state == RPQ_UNLOCKED
        && frame_cnt == 2'h0 && ctrl == RPQ_CTRL_RESET && readback == '0)
        else $error("reset did not clear the port");

    qual_thr3_c: cover property (
        ctrl.threshold == 2'b11 ##1 $rose(qualified));
    discard_c: cover property (ctrl.discard_en && pkt_valid && !pkt_fwd);
    wdog_c: cover property (drop_wdog ##1 !qualified);
    parity_dip_c: cover property (qualified ##1 !qualified ##1 qualified);
    parity_hold_c: cover property (drop_parity ##1 !qualified ##1 !qualified);

endmodule // rpq_port_qualifier

//--- rpq_video_src.sv
// Remote serializer model: streams video lines, frame ends, parity hits
module rpq_video_src (
    input wire logic clk_sys,
    output rpq_pkg::rpq_video_t video
);
    timeunit 1ns;
    timeprecision 100ps;
    import rpq_pkg::*;

    logic [15:0] last_len = 16'h0000;

    // Quiet link at time zero
    initial begin
        video = '0;
    end

    // Idle: the released length bus shows the inverse of its last value,
    // so a design that samples it outside line ends sees garbage
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            video <= '{1'b0, ~last_len, 1'b0, 1'b0};
        end
    endtask

    // One frame: nl lines of length len, gap idle cycles before each
    task automatic frame(input int nl, input logic [15:0] len,
                         input int gap);
        for (int i = 0; i < nl; i++) begin
            idle(gap);
            @(negedge clk_sys);
            last_len = len;
            video <= '{1'b1, len, 1'b0, 1'b0};
        end
        @(negedge clk_sys);
        video <= '{1'b0, ~last_len, 1'b1, 1'b0};
        idle(1);
    endtask

    // Single-cycle parity error outside any line
    task automatic parity_hit();
        @(negedge clk_sys);
        video <= '{1'b0, ~last_len, 1'b0, 1'b1};
        idle(1);
    endtask
endmodule // rpq_video_src

//--- tb_rpq_port_qualifier.sv
// Self-checking bench for the receive-port pass qualifier
module tb_rpq_port_qualifier;
    timeunit 1ns;
    timeprecision 100ps;
    import rpq_pkg::*;

    logic clk_sys, srst, reg_port_sel, reg_wr, rx_lock, pkt_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic pkt_fwd, qualified;
    logic [31:0] obs;
    logic [15:0] len, len2;
    rpq_video_t video;
    rpq_readback_t readback;
    logic [7:0] kmask [4] = '{8'h20, 8'h10, 8'h08, 8'h00};
    int n_errors = 0;
    int cmp_count = 0;
    int nl, nl2, dip;
    int q_sel[$];
    logic [31:0] q_exp[$];

    rpq_port_qualifier dut (.clk_sys(clk_sys), .srst(srst),
        .reg_port_sel(reg_port_sel), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rx_lock(rx_lock), .video(video),
        .pkt_valid(pkt_valid), .pkt_fwd(pkt_fwd),
        .qualified(qualified), .readback(readback));
    rpq_video_src src (.clk_sys(clk_sys), .video(video));

    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Checking and reporting
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] e);
        cmp_count++;
        if (seen !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, e);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Expectation note: 0 qualified, 1 rdata, 2 readback, 3 fwd, 4 dips
    task automatic note(input int sel, input logic [31:0] e);
        @(negedge clk_sys);
        q_sel.push_back(sel);
        q_exp.push_back(e);
    endtask

    // Monitor: 1 ns after the falling edge all outputs have settled
    always begin
        @(negedge clk_sys);
        #1;
        while (q_sel.size() > 0) begin
            case (q_sel[0])
                0: obs = {31'h0, qualified};
                1: obs = {24'h0, reg_rdata};
                2: obs = readback;
                3: obs = {31'h0, pkt_fwd};
                default: obs = 32'(dip);
            endcase
            void'(q_sel.pop_front());
            check(obs, q_exp.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    task automatic wr(input logic sel, input logic [7:0] v);
        @(negedge clk_sys);
        {reg_port_sel, reg_addr, reg_wdata} <= {sel, RPQ_CTRL_OFFSET, v};
        reg_wr <= 1'b1;
        @(negedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic sel, input logic [7:0] a,
                      input logic [7:0] e);
        @(negedge clk_sys);
        {reg_port_sel, reg_addr} <= {sel, a};
        note(1, {24'h0, e});
    endtask

    // Bounded wait for a qualified level, then note it
    task automatic wait_q(input logic v, input int lim);
        for (int i = 0; i < lim && qualified !== v; i++) begin
            @(negedge clk_sys);
        end
        note(0, {31'h0, v});
    endtask

    // Count cycles spent unqualified; a one-cycle drop is caught too
    task automatic count_low(input int n);
        dip = 0;
        repeat (n) begin
            @(negedge clk_sys);
            dip += int'(qualified === 1'b0);
        end
    endtask

    // Drop lock, program the port, relock
    task automatic start(input logic [7:0] c);
        @(negedge clk_sys);
        rx_lock <= 1'b0;
        wait_q(0, 3);
        wr(1, c);
        @(negedge clk_sys);
        rx_lock <= 1'b1;
        src.idle(4);
    endtask

    // Hang guard: far beyond the roughly 1000 cycles the tests take
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {srst, reg_port_sel, reg_wr, rx_lock, pkt_valid} = 5'b10000;
        {reg_addr, reg_wdata} = 16'h0000;
        void'($urandom(22));
        repeat (3) @(negedge clk_sys);
        srst <= 1'b0;
        note(0, 0);
        rd(1, RPQ_CTRL_OFFSET, RPQ_CTRL_RESET);
        d = 8'($urandom);
        wr(1, d);
        rd(1, RPQ_CTRL_OFFSET, d);
        wr(0, ~d);
        rd(1, RPQ_CTRL_OFFSET, d);
        rd(0, RPQ_CTRL_OFFSET, 8'h00);
        rd(1, 8'h7C, 8'h00);
        $display("test registers done");
        // Threshold zero: lock qualifies, watchdog has no say
        pkt_valid <= 1'b1;
        start(8'h80);
        note(0, 1);
        note(3, 1);
        repeat (3) src.frame(3, 16'h0040, 2);
        fork
            src.idle(150);
            count_low(150);
        join
        note(4, 0);
        note(0, 1);
        $display("test lock qualify done");
        // Drop causes with threshold two, watchdog off
        for (int k = 0; k < 4; k++) begin
            nl = $urandom_range(5, 2);
            len = 16'($urandom_range(16'hFFFE, 1));
            nl2 = nl + int'(k == 0);
            len2 = (k == 1) ? len ^ 16'h0001 : len;
            start(8'hC6 | kmask[k]);
            note(2, 0);
            note(3, 0);
            src.frame(nl, len, 3);
            note(0, 0);
            src.frame(nl, len, 3);
            wait_q(1, 4);
            note(2, {16'(nl), len});
            note(3, 1);
            if (k < 2) begin
                src.frame(nl2, len2, 3);
                wait_q(0, 4);
            end else begin
                fork
                    src.parity_hit();
                    count_low(8);
                join
                if (k == 3) note(4, 1);
                else note(0, 0);
            end
            if (k < 3) begin
                repeat (2) src.frame(nl2, len2, 3);
                wait_q(1, 4);
            end
            $display("test drop cause %0d done", k);
        end
        // Watchdog enabled at threshold one, then disabled at threshold three
        for (int w = 0; w < 2; w++) begin
            // Second pass: threshold three with the watchdog disabled
            start(8'h01 | 8'(w * 6));
            note(3, 1);
            repeat (2) src.frame(4, 16'h0100, 3);
            note(0, 32'(1 - w));
            src.frame(4, 16'h0100, 3);
            wait_q(1, 4);
            src.idle(150);
            note(0, 32'(w));
            note(2, {16'h0004, 16'h0100});
            $display("test watchdog %0d done", w);
        end
        // Reset in mid-run: port clears, then requalifies on lock
        @(negedge clk_sys);
        srst <= 1'b1;
        note(0, 0);
        note(2, 0);
        srst <= 1'b0;
        rd(1, RPQ_CTRL_OFFSET, RPQ_CTRL_RESET);
        note(0, 1);
        $display("test reset done");
        repeat (3) @(negedge clk_sys);
        report_and_stop();
    end
endmodule // tb_rpq_port_qualifier
